// ### rtl/sep_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SEP_REGS_SVH
`define SEP_REGS_SVH

// ----------------------------------------------------------------
// Register offsets on the special function register port
// ----------------------------------------------------------------
`define SEP_ADDR_DATA      8'h9E
`define SEP_ADDR_CMD       8'h9F

// ----------------------------------------------------------------
// Command and status register fields
// ----------------------------------------------------------------
`define SEP_BIT_ERROR      7
`define SEP_BIT_BUSY       6
`define SEP_BIT_RXACK      5
`define SEP_BIT_TXACK      4
`define SEP_BIT_WAITRDY    7
`define SEP_BIT_FLOAT      5
`define SEP_BIT_READ       4
`define SEP_RST_RXACK      1'b1
`define SEP_RST_TXACK      1'b1
`define SEP_RST_ERROR      1'b0

// ----------------------------------------------------------------
// Two-pin command codes and pin select codes
// ----------------------------------------------------------------
`define SEP_CMD_NOP        4'h0
`define SEP_CMD_RECV       4'h2
`define SEP_CMD_XMIT       4'h3
`define SEP_CMD_STOP       4'h5
`define SEP_CMD_LAST       4'h6
`define SEP_CMD_START      4'h9
`define SEP_SEL_TWOPIN     2'h1
`define SEP_SEL_SHARED     2'h2
`define SEP_SEL_SPLIT      2'h3
`define SEP_MAX_COUNT      4'h8

// ----------------------------------------------------------------
// Timing: clock rate and serial clock rates in hertz
// ----------------------------------------------------------------
`define SEP_CLK_HZ         25000000
`define SEP_TWOPIN_HZ      78000
`define SEP_THREEW_HZ      500000
`define SEP_TWOPIN_HALF    (`SEP_CLK_HZ / (2 * `SEP_TWOPIN_HZ))
`define SEP_THREEW_HALF    (`SEP_CLK_HZ / (2 * `SEP_THREEW_HZ))

`endif

// ### rtl/sep_pkg.sv
// Types shared by the serial EEPROM master port
package sep_pkg;

    // Word queued from the register port toward the engine
    typedef struct packed {
        logic       isCmd;
        logic [7:0] value;
    } sep_word_t;

    // Engine states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_STOP  = 3'b010,
        ST_BYTE  = 3'b011,
        ST_BITS  = 3'b100,
        ST_WAIT  = 3'b101
    } sep_state_t;

endpackage

// ### rtl/sep_eeprom_port.sv
// Serial EEPROM master port with its register write queue
`timescale 1ns/1ps
`include "sep_regs.svh"

// ----------------------------------------------------------------
// Register write queue
// ----------------------------------------------------------------
module sep_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // Filling side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wrPtr_q, wrPtr_d;
    logic [AW-1:0]    rdPtr_q, rdPtr_d;
    logic [AW:0]      count_q, count_d;
    logic             full_q, full_d;
    logic             empty_q, empty_d;
    logic             push, pop;

    // Full and empty are registered so both ready and valid are clean
    always_comb begin
        push    = inValid && !full_q;
        pop     = outReady && !empty_q;
        wrPtr_d = push ? AW'((wrPtr_q + 1'b1) % DEPTH) : wrPtr_q;
        rdPtr_d = pop ? AW'((rdPtr_q + 1'b1) % DEPTH) : rdPtr_q;
        count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
        full_d  = (count_d == (AW+1)'(DEPTH));
        empty_d = (count_d == '0);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            full_q  <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
            full_q  <= full_d;
            empty_q <= empty_d;
        end
    end

    // Storage holds no control state, so it needs no reset
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    assign inReady  = !full_q;
    assign outValid = !empty_q;
    assign outData  = mem_q[rdPtr_q];
endmodule

// ----------------------------------------------------------------
// Serial EEPROM master port
// ----------------------------------------------------------------
module sep_eeprom_port #(
    parameter int QUEUE_DEPTH = 16
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Special function register port
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrite,
    input  wire logic [7:0] sfrWrData,
    input  wire logic       sfrRead,
    output logic      [7:0] sfrRdData,
    output logic            sfrWrReady,
    // Interface select from the pin configuration
    input  wire logic [1:0] eepromPinSelect,
    // Serial pins
    output logic            serialClockPinOut,
    output logic            serialClockPinOe,
    input  wire logic       serialDataPinIn,
    output logic            serialDataPinOut,
    output logic            serialDataPinOe,
    input  wire logic       serialInputPin,
    // Completion interrupt
    output logic            eepromInterrupt
);
    localparam logic [8:0] HALF_TWO = 9'(`SEP_TWOPIN_HALF - 1);
    localparam logic [8:0] HALF_THR = 9'(`SEP_THREEW_HALF - 1);

    // Queue signals
    sep_pkg::sep_word_t qIn, qOut;
    logic               qValid, qPop, qInValid;

    // Engine state
    sep_pkg::sep_state_t state_q, state_d;
    logic [8:0] div_q, div_d;
    logic [4:0] ph_q, ph_d;
    logic [7:0] data_q, data_d;
    logic [7:0] ctl_q, ctl_d;
    logic       scl_q, scl_d;
    logic       sda_q, sda_d;
    logic       drv_q, drv_d;
    logic       err_q, err_d;
    logic       rxAck_q, rxAck_d;
    logic       txAck_q, txAck_d;
    logic       busy_q, busy_d;
    logic       prevIn_q;
    logic       tick, din, lastPh;
    logic [4:0] endPh;

    // Pin synchronisers and output flops
    logic       dataS1_q, dataS2_q, inS1_q, inS2_q;
    logic       clkOut_q, clkOe_q, datOut_q, datOe_q;
    logic       clkOut_d, clkOe_d, datOut_d, datOe_d;
    logic [7:0] rd_q, rd_d;
    logic       irq_q;

    // ------------------------------------------------------------
    // Register writes go through the queue to keep their order
    // ------------------------------------------------------------
    always_comb begin
        qInValid    = sfrWrite && (sfrAddr == `SEP_ADDR_DATA ||
                                   sfrAddr == `SEP_ADDR_CMD);
        qIn.isCmd   = (sfrAddr == `SEP_ADDR_CMD);
        qIn.value   = sfrWrData;
    end

    sep_fifo #(
        .WIDTH ($bits(sep_pkg::sep_word_t)),
        .DEPTH (QUEUE_DEPTH)
    ) u_queue (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .inValid  (qInValid),
        .inReady  (sfrWrReady),
        .inData   (qIn),
        .outValid (qValid),
        .outReady (qPop),
        .outData  (qOut)
    );

    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dataS1_q <= 1'b1;
            dataS2_q <= 1'b1;
            inS1_q   <= 1'b1;
            inS2_q   <= 1'b1;
        end else begin
            dataS1_q <= serialDataPinIn;
            dataS2_q <= dataS1_q;
            inS1_q   <= serialInputPin;
            inS2_q   <= inS1_q;
        end
    end

    // Split mode reads pin eight, otherwise the shared data pin
    assign din = (eepromPinSelect == `SEP_SEL_SPLIT) ? inS2_q
                                                      : dataS2_q;

    // ------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------
    always_comb begin
        tick    = (div_q == '0);
        endPh   = 5'({ctl_q[3:0], 1'b0});
        lastPh  = (ph_q == endPh - 5'h1);
        state_d = state_q;
        div_d   = tick ? ((eepromPinSelect == `SEP_SEL_TWOPIN) ?
                          HALF_TWO : HALF_THR) : div_q - 9'h1;
        ph_d    = ph_q;
        data_d  = data_q;
        ctl_d   = ctl_q;
        scl_d   = scl_q;
        sda_d   = sda_q;
        drv_d   = drv_q;
        err_d   = err_q;
        rxAck_d = rxAck_q;
        txAck_d = txAck_q;
        qPop    = 1'b0;
        unique case (state_q)
            sep_pkg::ST_IDLE: begin
                div_d = (eepromPinSelect == `SEP_SEL_TWOPIN) ?
                        HALF_TWO : HALF_THR;
                ph_d  = '0;
                if (qValid) begin
                    qPop = 1'b1;
                    if (!qOut.isCmd) begin
                        data_d = qOut.value;
                    end else if (eepromPinSelect == `SEP_SEL_TWOPIN) begin
                        ctl_d = qOut.value;
                        err_d = 1'b0;
                        case (qOut.value[3:0])
                            // Clock already rests high, so a no-op holds it
                            `SEP_CMD_NOP:   scl_d = 1'b1;
                            `SEP_CMD_START: state_d = sep_pkg::ST_START;
                            `SEP_CMD_STOP:  state_d = sep_pkg::ST_STOP;
                            `SEP_CMD_XMIT,
                            `SEP_CMD_RECV,
                            `SEP_CMD_LAST:  state_d = sep_pkg::ST_BYTE;
                            default:        err_d = 1'b1;
                        endcase
                    end else if (eepromPinSelect[1]) begin
                        ctl_d = qOut.value;
                        scl_d = 1'b0;
                        if (qOut.value[3:0] == 4'h0) begin
                            // No clocks: only the float setting applies
                            drv_d = !qOut.value[`SEP_BIT_FLOAT];
                        end else begin
                            state_d = sep_pkg::ST_BITS;
                            drv_d   = !qOut.value[`SEP_BIT_READ] ||
                                      (eepromPinSelect == `SEP_SEL_SPLIT);
                        end
                    end
                end
            end
            sep_pkg::ST_START: begin
                // Data falls while the clock is high
                if (tick) begin
                    ph_d = ph_q + 5'h1;
                    if (ph_q == 5'h0) begin
                        sda_d = 1'b1;
                        scl_d = 1'b1;
                    end else begin
                        sda_d   = 1'b0;
                        state_d = sep_pkg::ST_IDLE;
                    end
                end
            end
            sep_pkg::ST_STOP: begin
                // Clock low with data low, clock high, then data rises
                if (tick) begin
                    ph_d = ph_q + 5'h1;
                    if (ph_q == 5'h0) begin
                        scl_d = 1'b0;
                        sda_d = 1'b0;
                    end else if (ph_q == 5'h1) begin
                        scl_d = 1'b1;
                    end else begin
                        sda_d   = 1'b1;
                        state_d = sep_pkg::ST_IDLE;
                    end
                end
            end
            sep_pkg::ST_BYTE: begin
                // Even phases drive with clock low, odd phases sample high
                if (tick) begin
                    ph_d  = ph_q + 5'h1;
                    scl_d = ph_q[0];
                    if (!ph_q[0]) begin
                        if (ph_q == 5'd16) begin
                            // Acknowledge slot
                            sda_d = (ctl_q[3:0] != `SEP_CMD_RECV);
                        end else begin
                            sda_d = (ctl_q[3:0] == `SEP_CMD_XMIT) ?
                                    data_q[7] : 1'b1;
                        end
                    end else if (ph_q != 5'd17) begin
                        // Sampling the line keeps a sent byte intact
                        data_d = {data_q[6:0], din};
                    end else begin
                        if (ctl_q[3:0] == `SEP_CMD_XMIT) begin
                            rxAck_d = !din;
                        end else begin
                            txAck_d = (ctl_q[3:0] == `SEP_CMD_RECV);
                        end
                        // Data holds: a change with the clock high is a start or a stop
                        state_d = sep_pkg::ST_IDLE;
                    end
                end
            end
            sep_pkg::ST_BITS: begin
                if (tick) begin
                    ph_d = ph_q + 5'h1;
                    if (ph_q == endPh) begin
                        // Clock returns low after the last bit
                        scl_d   = 1'b0;
                        state_d = (ctl_q[`SEP_BIT_WAITRDY] &&
                                   ctl_q[`SEP_BIT_FLOAT]) ?
                                  sep_pkg::ST_WAIT : sep_pkg::ST_IDLE;
                    end else if (!ph_q[0]) begin
                        // Falling edge: present the next data bit
                        scl_d = 1'b0;
                        sda_d = data_q[7];
                    end else begin
                        // Rising edge: shift, sampling the line only on a read
                        scl_d  = 1'b1;
                        data_d = ctl_q[`SEP_BIT_READ] ?
                                 {data_q[6:0], din} :
                                 {data_q[6:0], 1'b0};
                        if (lastPh && ctl_q[`SEP_BIT_FLOAT]) begin
                            drv_d = 1'b0;
                        end
                    end
                end
            end
            sep_pkg::ST_WAIT: begin
                // Busy holds until the device pulls the line back up
                if (din && !prevIn_q) begin
                    state_d = sep_pkg::ST_IDLE;
                end
            end
            default: state_d = sep_pkg::ST_IDLE;
        endcase
        busy_d = (state_d != sep_pkg::ST_IDLE) || qValid;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q  <= sep_pkg::ST_IDLE;
            div_q    <= '0;
            ph_q     <= '0;
            data_q   <= '0;
            ctl_q    <= '0;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            drv_q    <= 1'b1;
            err_q    <= `SEP_RST_ERROR;
            rxAck_q  <= `SEP_RST_RXACK;
            txAck_q  <= `SEP_RST_TXACK;
            busy_q   <= 1'b0;
            prevIn_q <= 1'b1;
        end else begin
            state_q  <= state_d;
            div_q    <= div_d;
            ph_q     <= ph_d;
            data_q   <= data_d;
            ctl_q    <= ctl_d;
            scl_q    <= scl_d;
            sda_q    <= sda_d;
            drv_q    <= drv_d;
            err_q    <= err_d;
            rxAck_q  <= rxAck_d;
            txAck_q  <= txAck_d;
            busy_q   <= busy_d;
            prevIn_q <= din;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers, read data and completion pulse
    // ------------------------------------------------------------
    always_comb begin
        clkOut_d = scl_q;
        clkOe_d  = 1'b0;
        datOut_d = 1'b0;
        datOe_d  = 1'b0;
        if (eepromPinSelect == `SEP_SEL_TWOPIN) begin
            // Data is open drain: only a low level is driven
            clkOe_d  = 1'b1;
            datOe_d  = !sda_q;
        end else if (eepromPinSelect[1]) begin
            clkOe_d  = 1'b1;
            datOut_d = sda_q;
            datOe_d  = drv_q;
        end
        rd_d = 8'h00;
        if (sfrRead && sfrAddr == `SEP_ADDR_DATA) begin
            rd_d = data_q;
        end else if (sfrRead && sfrAddr == `SEP_ADDR_CMD) begin
            rd_d[`SEP_BIT_ERROR] = err_q;
            rd_d[`SEP_BIT_BUSY]  = busy_q;
            rd_d[`SEP_BIT_RXACK] = rxAck_q;
            rd_d[`SEP_BIT_TXACK] = txAck_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            clkOut_q <= 1'b1;
            clkOe_q  <= 1'b0;
            datOut_q <= 1'b0;
            datOe_q  <= 1'b0;
            rd_q     <= 8'h00;
            irq_q    <= 1'b0;
        end else begin
            clkOut_q <= clkOut_d;
            clkOe_q  <= clkOe_d;
            datOut_q <= datOut_d;
            datOe_q  <= datOe_d;
            rd_q     <= rd_d;
            irq_q    <= busy_q && !busy_d;
        end
    end

    assign serialClockPinOut = clkOut_q;
    assign serialClockPinOe  = clkOe_q;
    assign serialDataPinOut  = datOut_q;
    assign serialDataPinOe   = datOe_q;
    assign sfrRdData         = rd_q;
    assign eepromInterrupt   = irq_q;
endmodule

// ### sim/sep_eeprom_port_props.sv
// Pin and interrupt checker bound to the serial EEPROM master port
`timescale 1ns/1ps
module sep_eeprom_port_props (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       reset,
    // Watched ports
    input wire logic [1:0] eepromPinSelect,
    input wire logic       serialClockPinOut,
    input wire logic       serialClockPinOe,
    input wire logic       serialDataPinOut,
    input wire logic       eepromInterrupt
);
    logic [15:0] lowCnt_q;
    logic [15:0] lowCnt_d;
    // Low phase length; saturates so a long rest cannot wrap
    always_comb begin
        lowCnt_d = serialClockPinOut ? 16'h0000 : lowCnt_q + 16'h0001;
        if (!serialClockPinOut && &lowCnt_q) lowCnt_d = lowCnt_q;
    end
    always_ff @(posedge ref_clk) begin
        lowCnt_q <= reset ? 16'h0000 : lowCnt_d;
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    property p_twoPinLow;
        $rose(serialClockPinOut) && eepromPinSelect == 2'h1
            |-> lowCnt_q == 16'h00A0;
    endproperty
    a_twoPinLow: assert property (p_twoPinLow)
        else $error("two-pin clock low half is not 160 cycles");
    property p_twoPinRest;
        eepromPinSelect == 2'h1 && $past(eepromPinSelect) == 2'h1
            |-> lowCnt_q <= 16'h00A0;
    endproperty
    a_twoPinRest: assert property (p_twoPinRest)
        else $error("two-pin clock held low too long");
    property p_threeLow;
        $rose(serialClockPinOut) && eepromPinSelect >= 2'h2
            |-> lowCnt_q >= 16'h0019;
    endproperty
    a_threeLow: assert property (p_threeLow)
        else $error("three-wire clock low half too short");
    property p_oeTwoPin;
        !$past(reset) && $past(eepromPinSelect) == 2'h1 |-> serialClockPinOe;
    endproperty
    a_oeTwoPin: assert property (p_oeTwoPin)
        else $error("two-pin clock not driven");
    property p_oeThree;
        !$past(reset) && $past(eepromPinSelect) >= 2'h2 |-> serialClockPinOe;
    endproperty
    a_oeThree: assert property (p_oeThree)
        else $error("three-wire clock not driven");
    property p_openDrain;
        !$past(reset) && $past(eepromPinSelect) == 2'h1 |-> !serialDataPinOut;
    endproperty
    a_openDrain: assert property (p_openDrain)
        else $error("two-pin data drives high");
    property p_intPulse;
        eepromInterrupt |=> !eepromInterrupt;
    endproperty
    a_intPulse: assert property (p_intPulse)
        else $error("interrupt longer than one cycle");
    property p_splitHold;
        $rose(serialClockPinOut) && eepromPinSelect == 2'h3
            |-> $stable(serialDataPinOut) ##1 $stable(serialDataPinOut)[*8];
    endproperty
    a_splitHold: assert property (p_splitHold)
        else $error("split data changed around rising clock");
endmodule
bind sep_eeprom_port sep_eeprom_port_props u_props (
    .ref_clk          (ref_clk),
    .reset            (reset),
    .eepromPinSelect  (eepromPinSelect),
    .serialClockPinOut(serialClockPinOut),
    .serialClockPinOe (serialClockPinOe),
    .serialDataPinOut (serialDataPinOut),
    .eepromInterrupt  (eepromInterrupt)
);

// ### sim/sep_eeprom_model.sv
// Behavioural serial EEPROM standing on the far side of the port
`timescale 1ns/1ps
module sep_eeprom_model (
    // Serial lines
    input  wire logic       sclk,
    input  wire logic       lineIn,
    output logic            pullLow,
    output logic            dataOut,
    // Bench control
    input  wire logic [9:0] loadVal,
    input  wire logic       load,
    input  wire logic       holdLow,
    output logic      [9:0] captured
);
    logic [9:0] shiftQ = 10'h3FF;
    initial dataOut = 1'b1;
    initial captured = 10'h000;
    // First bit shows at load; ones refill so the line is let go
    always @(posedge load or negedge sclk) begin
        if (load) begin
            dataOut = loadVal[9];
            shiftQ = {loadVal[8:0], 1'b1};
        end else begin
            dataOut = shiftQ[9];
            shiftQ = {shiftQ[8:0], 1'b1};
        end
    end
    // Line seen at each rising clock
    always @(posedge sclk) captured <= {captured[8:0], lineIn};
    // Busy memory holds the line low; open drain otherwise
    assign pullLow = holdLow | !dataOut;
endmodule

// ### sim/tb.sv
// Register-level testbench for the serial EEPROM master port
`timescale 1ns/1ps
`include "sep_regs.svh"
`define CHK(got, exp) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); \
    end \
end
module tb;
    logic       ref_clk = 1'b0;
    logic       reset = 1'b1;
    logic [7:0] sfrAddr = 8'h00;
    logic       sfrWrite = 1'b0;
    logic [7:0] sfrWrData = 8'h00;
    logic       sfrRead = 1'b0;
    logic [1:0] eepromPinSelect = 2'h0;
    logic [9:0] loadVal = 10'h3FF;
    logic       load = 1'b0;
    logic       holdLow = 1'b0;
    logic       chipSel = 1'b0;
    logic [7:0] rd;
    logic [9:0] captured;
    logic [9:0] cap0;
    logic [3:0] bad [10] = '{4'h1, 4'h4, 4'h7, 4'h8, 4'hA, 4'hB, 4'hC,
                             4'hD, 4'hE, 4'hF};
    int         mismatches = 0;
    int         checks = 0;
    int         intCount = 0;
    wire logic [7:0] sfrRdData;
    wire logic sfrWrReady, serialClockPinOut, serialClockPinOe;
    wire logic serialDataPinOut, serialDataPinOe, eepromInterrupt;
    wire logic modelPull, modelBit, lineLevel;
    // Pin three has a pull-up; the memory lets go in split mode, or when deselected outside two-pin mode
    assign lineLevel = serialDataPinOe ? serialDataPinOut
                     : !(modelPull && eepromPinSelect != 2'h3 &&
                         (chipSel || eepromPinSelect == 2'h1));
    sep_eeprom_port uut (
        .ref_clk(ref_clk), .reset(reset), .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite), .sfrWrData(sfrWrData), .sfrRead(sfrRead),
        .sfrRdData(sfrRdData), .sfrWrReady(sfrWrReady),
        .eepromPinSelect(eepromPinSelect),
        .serialClockPinOut(serialClockPinOut),
        .serialClockPinOe(serialClockPinOe), .serialDataPinIn(lineLevel),
        .serialDataPinOut(serialDataPinOut),
        .serialDataPinOe(serialDataPinOe), .serialInputPin(modelBit),
        .eepromInterrupt(eepromInterrupt)
    );
    sep_eeprom_model far (
        .sclk(serialClockPinOut), .lineIn(lineLevel), .pullLow(modelPull),
        .dataOut(modelBit), .loadVal(loadVal), .load(load),
        .holdLow(holdLow), .captured(captured)
    );
    always #20 ref_clk = ~ref_clk;
    // Count completion pulses
    always @(posedge ref_clk) if (eepromInterrupt === 1'b1) intCount++;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfrAddr <= a;
        sfrWrData <= d;
        sfrWrite <= 1'b1;
        @(posedge ref_clk);
        sfrWrite <= 1'b0;
    endtask
    task automatic rdReg(input logic [7:0] a);
        @(posedge ref_clk);
        sfrAddr <= a;
        sfrRead <= 1'b1;
        @(posedge ref_clk);
        sfrRead <= 1'b0;
        #1 rd = sfrRdData;
    endtask
    // Polls busy; a bounded wait so a stuck engine cannot hang the run
    task automatic waitIdle();
        int n;
        n = 0;
        do begin
            rdReg(`SEP_ADDR_CMD);
            n++;
        end while (rd[`SEP_BIT_BUSY] !== 1'b0 && n < 4000);
        if (n >= 4000) mismatches++;
    endtask
    task automatic ld(input logic [9:0] v);
        loadVal <= v;
        @(posedge ref_clk);
        load <= 1'b1;
        @(posedge ref_clk);
        load <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] c);
        int n0;
        // A lone data write blips busy; let its pulse be counted first
        repeat (4) @(posedge ref_clk);
        n0 = intCount;
        wr(`SEP_ADDR_CMD, c);
        waitIdle();
        repeat (3) @(posedge ref_clk);
        `CHK(intCount, n0 + 1)
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge ref_clk);
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        rdReg(`SEP_ADDR_CMD);
        `CHK(rd, 8'h30)
        rdReg(8'h9D);
        `CHK(rd, 8'h00)
        eepromPinSelect <= `SEP_SEL_TWOPIN;
        cmd(8'h09);
        `CHK({serialClockPinOut, lineLevel}, 2'h2)
        wr(`SEP_ADDR_DATA, 8'hA5);
        ld(10'h3FE);
        cmd(8'h03);
        `CHK(captured[8:1], 8'hA5)
        `CHK(rd[7:5], 3'h1)
        ld(10'h3FF);
        cmd(8'h03);
        `CHK(rd[`SEP_BIT_RXACK], 1'b0)
        ld(10'h279);
        cmd(8'h02);
        `CHK({rd[`SEP_BIT_TXACK], captured[0]}, 2'h2)
        rdReg(`SEP_ADDR_DATA);
        `CHK(rd, 8'h3C)
        ld(10'h387);
        cmd(8'h06);
        `CHK({rd[`SEP_BIT_TXACK], captured[0]}, 2'h1)
        rdReg(`SEP_ADDR_DATA);
        `CHK(rd, 8'hC3)
        cmd(8'h05);
        `CHK({serialClockPinOut, lineLevel}, 2'h3)
        cap0 = captured;
        foreach (bad[i]) begin
            wr(`SEP_ADDR_CMD, {4'h0, bad[i]});
            waitIdle();
            `CHK(rd[`SEP_BIT_ERROR], 1'b1)
            `CHK(captured, cap0)
        end
        wr(`SEP_ADDR_CMD, 8'h00);
        waitIdle();
        `CHK({rd[`SEP_BIT_ERROR], serialClockPinOut}, 2'h1)
        // Queue fills behind a running transmit and refuses the extra
        ld(10'h3FE);
        wr(`SEP_ADDR_CMD, 8'h03);
        for (int i = 0; i < 17; i++) begin
            @(posedge ref_clk);
            sfrAddr <= `SEP_ADDR_DATA;
            sfrWrData <= 8'(i);
            sfrWrite <= 1'b1;
        end
        @(posedge ref_clk);
        sfrWrite <= 1'b0;
        #1 `CHK(sfrWrReady, 1'b0)
        waitIdle();
        rdReg(`SEP_ADDR_DATA);
        `CHK(rd, 8'h0F)
        // Three-wire on the shared pin
        chipSel <= 1'b1;
        eepromPinSelect <= `SEP_SEL_SHARED;
        wr(`SEP_ADDR_DATA, 8'h96);
        cmd(8'h08);
        `CHK({captured[7:0], serialDataPinOe}, 9'h12D)
        wr(`SEP_ADDR_DATA, 8'hC0);
        cmd(8'h22);
        `CHK({captured[1:0], serialDataPinOe}, 3'h6)
        ld(10'h2DF);
        cmd(8'h35);
        rdReg(`SEP_ADDR_DATA);
        `CHK(rd[4:0], 5'h16)
        chipSel <= 1'b0;
        cap0 = captured;
        wr(`SEP_ADDR_CMD, 8'h00);
        waitIdle();
        `CHK({captured, serialDataPinOe}, {cap0, 1'b1})
        chipSel <= 1'b1;
        holdLow <= 1'b1;
        wr(`SEP_ADDR_CMD, 8'hA1);
        repeat (200) @(posedge ref_clk);
        rdReg(`SEP_ADDR_CMD);
        `CHK(rd[`SEP_BIT_BUSY], 1'b1)
        holdLow <= 1'b0;
        waitIdle();
        // Split pins: data in on pin eight
        eepromPinSelect <= `SEP_SEL_SPLIT;
        ld(10'h16B);
        cmd(8'h18);
        rdReg(`SEP_ADDR_DATA);
        `CHK(rd, 8'h5A)
        give_verdict();
    end
endmodule
